// ---- include/dsc_pkg.sv ----
package dsc_pkg;

	localparam int CHANNELS    = 4;
	localparam int PHASE_W     = 16;
	localparam int OUT_W       = 12;
	localparam int USER_W      = 1;
	localparam int IDX_W       = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
	localparam int TUSER_W     = USER_W + IDX_W;
	localparam int LATENCY     = 1;
	localparam int BP_MIN_LAT  = 6;
	localparam int FIFO_DEPTH  = 4;
	localparam logic [PHASE_W-1:0] QUARTER_TURN = 16'h4000;
	localparam logic [PHASE_W-1:0] RESET_PHASE  = 16'h0000;

	typedef enum logic [1:0] {
		FRAME_NONE,
		FRAME_VECTOR,
		FRAME_PACKET,
		FRAME_CONFIG
	} dsc_framing_t;

	typedef enum logic [1:0] {
		TU_NONE,
		TU_CHAN,
		TU_USER,
		TU_BOTH
	} dsc_tuser_mode_t;

	typedef enum logic {
		SYNC_VECTOR,
		SYNC_PACKET
	} dsc_sync_t;

	typedef struct packed {
		logic [PHASE_W-1:0] phase_increment_value;
		logic [PHASE_W-1:0] phase_offset_value;
		logic               resync;
		logic               last;
		logic [TUSER_W-1:0] user;
	} dsc_phase_in_t;

	typedef struct packed {
		logic [PHASE_W-1:0] phase_increment_value;
		logic [PHASE_W-1:0] phase_offset_value;
	} dsc_config_t;

	typedef struct packed {
		logic [PHASE_W-1:0] phase;
		logic [OUT_W-1:0]   sine;
		logic [OUT_W-1:0]   cosine;
		logic               last;
		logic [TUSER_W-1:0] data_user;
		logic [TUSER_W-1:0] phase_user;
	} dsc_sample_t;

endpackage : dsc_pkg

// ---- design/dsc_channel_ctrl.sv ----
// Overview of operation
// - without framing no frame-end on phase or outputs; config frame-end marks last channel
// - vector framing: frame-end on last channel of each cycle, in and out
// - vector framing: pulse missing or unexpected event on frame-end mismatch with counter
// - packet framing: input frame-end reaches outputs with data latency exactly
// - config framing: output frame-end on last channel before new configuration applies
// - ready option gives full handshakes with back pressure; otherwise no stall
// - input user field forces user field onto every output side-band
// - index mode: pulse mismatch event when input index differs from channel counter
// - user mode: side-band content ignored and passed unchanged with its sample
// - index sits in low side-band bits, minimal width for the channel count
// - user width excludes index bits; total side-band is their sum
// - outputs two's complement by default, sign-magnitude as an option
// - config accepted any time, buffered until the synchronization point
// - on-vector sync applies buffered config when channel counter wraps
// - on-packet sync applies buffered config on phase input frame-end, only under packet framing
// - latency floor adds a cycle per streaming increment and block ROMs
// - with back pressure latency is at least 6 plus the floor
// - clock enable active high; all state holds while low
// - reset active low, sampled on the clock edge
// - slice-held increment and offset initialize to zero
// - register-held increment and offset load per-channel initial values on reset
// - resync: accumulated phase becomes the selected increment; output phase is increment plus offset
// - programmable increment from config stream, streaming one from phase input

module dsc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic             enable,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0]   count;
	logic             push;
	logic             pop;

	function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
		return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
	endfunction : bump

	assign in_ready  = (count < (PTR_W + 1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = enable && in_valid && in_ready;
	assign pop       = enable && out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= bump(rd_ptr);
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule : dsc_fifo

module dsc_channel_ctrl #(
	parameter int                               CHANNELS     = dsc_pkg::CHANNELS,
	parameter bit                               HAS_PHASE_IN = 1'b1,
	parameter bit                               HAS_TREADY   = 1'b0,
	parameter bit                               STREAM_INC   = 1'b0,
	parameter bit                               STREAM_OFF   = 1'b0,
	parameter bit                               BLOCK_ROM    = 1'b0,
	parameter bit                               TAYLOR_ROM   = 1'b0,
	parameter bit                               SLICE_REG    = 1'b0,
	parameter int                               LATENCY      = dsc_pkg::LATENCY,
	parameter int                               FIFO_DEPTH   = dsc_pkg::FIFO_DEPTH,
	parameter logic [CHANNELS*dsc_pkg::PHASE_W-1:0] INC_INIT = '0,
	parameter logic [CHANNELS*dsc_pkg::PHASE_W-1:0] OFF_INIT = '0
) (
	input  wire logic                     clock,
	input  wire logic                     reset_n,
	input  wire logic                     clock_en,
	input  wire dsc_pkg::dsc_framing_t    framing_mode,
	input  wire dsc_pkg::dsc_tuser_mode_t in_user_mode,
	input  wire dsc_pkg::dsc_tuser_mode_t data_user_mode,
	input  wire dsc_pkg::dsc_tuser_mode_t phase_user_mode,
	input  wire dsc_pkg::dsc_sync_t       sync_mode,
	input  wire logic                     sign_mag,
	input  wire logic                     s_phase_valid,
	output logic                          s_phase_ready,
	input  wire dsc_pkg::dsc_phase_in_t   s_phase,
	input  wire logic                     s_config_valid,
	output logic                          s_config_ready,
	input  wire dsc_pkg::dsc_config_t     s_config,
	input  wire logic                     s_config_last,
	output logic                          m_valid,
	input  wire logic                     m_ready,
	output dsc_pkg::dsc_sample_t          m_sample,
	output logic                          frame_end_missing_event,
	output logic                          frame_end_unexpected_event,
	output logic                          channel_index_mismatch_event
);
	import dsc_pkg::*;

	localparam int FLOOR   = int'(STREAM_INC) + int'(BLOCK_ROM) + int'(TAYLOR_ROM);
	localparam int LAT_MIN = HAS_TREADY ? BP_MIN_LAT + FLOOR : FLOOR;
	localparam int LAT_EFF = (LATENCY > LAT_MIN) ? LATENCY : ((LAT_MIN > 0) ? LAT_MIN : 1);
	localparam int TAP     = (LAT_EFF > 1) ? LAT_EFF - 2 : 0;
	localparam logic [IDX_W-1:0] LAST_CH = IDX_W'(CHANNELS - 1);

	logic [IDX_W-1:0]   chan;
	logic [IDX_W-1:0]   cfg_ptr;
	logic               pending;
	logic [PHASE_W-1:0] act_inc [CHANNELS];
	logic [PHASE_W-1:0] act_off [CHANNELS];
	logic [PHASE_W-1:0] sh_inc  [CHANNELS];
	logic [PHASE_W-1:0] sh_off  [CHANNELS];
	logic [PHASE_W-1:0] acc     [CHANNELS];
	dsc_sample_t        pipe    [TAP+1];
	logic               pvalid  [TAP+1];
	dsc_phase_in_t      in_word;
	dsc_sample_t        stage_in;
	dsc_sample_t        fifo_in;
	logic               fifo_in_valid;
	logic               fifo_in_ready;
	logic               advance;
	logic               take;
	logic               wrap;
	logic               apply_now;
	logic               cfg_take;
	logic [PHASE_W-1:0] inc_sel;
	logic [PHASE_W-1:0] off_sel;
	logic [PHASE_W-1:0] next_acc;
	logic [PHASE_W-1:0] phase_val;
	logic [PHASE_W-1:0] cos_phase;
	logic [IDX_W-1:0]   in_idx;
	logic [USER_W-1:0]  in_user;

	function automatic logic [OUT_W-1:0] out_form(input logic [OUT_W-1:0] x, input logic sm);
		logic [OUT_W-1:0] mag;
		mag = x[OUT_W-1] ? OUT_W'(~x + 1'b1) : x;
		return sm ? {x[OUT_W-1], mag[OUT_W-2:0]} : x;
	endfunction : out_form

	function automatic logic has_user(input dsc_tuser_mode_t m);
		return (m == TU_USER) || (m == TU_BOTH);
	endfunction : has_user

	function automatic logic [TUSER_W-1:0] out_user(input dsc_tuser_mode_t m, input dsc_tuser_mode_t im,
		input logic [USER_W-1:0] u, input logic [IDX_W-1:0] c);
		dsc_tuser_mode_t eff;
		eff = m;
		if (has_user(im)) begin
			eff = (m == TU_CHAN || m == TU_BOTH) ? TU_BOTH : TU_USER;
		end
		case (eff)
			TU_CHAN: return {{USER_W{1'b0}}, c};
			TU_USER: return TUSER_W'(u);
			TU_BOTH: return {u, c};
			default: return '0;
		endcase
	endfunction : out_user

	// path stalls when clock enable is low or when back pressure leaves the queue full
	assign advance        = clock_en && (!HAS_TREADY || fifo_in_ready);
	assign s_phase_ready  = HAS_TREADY ? advance : 1'b1;
	assign in_word        = HAS_PHASE_IN ? s_phase : '0;
	assign take           = advance && (!HAS_PHASE_IN || s_phase_valid);
	assign wrap           = take && (chan == LAST_CH);
	assign s_config_ready = clock_en;
	assign cfg_take       = s_config_valid && clock_en;
	assign apply_now      = pending && ((sync_mode == SYNC_VECTOR) ? wrap
		: (take && in_word.last && framing_mode == FRAME_PACKET));

	assign inc_sel   = STREAM_INC ? in_word.phase_increment_value : act_inc[chan];
	assign off_sel   = STREAM_OFF ? in_word.phase_offset_value : act_off[chan];
	assign next_acc  = in_word.resync ? inc_sel : PHASE_W'(acc[chan] + inc_sel);
	assign phase_val = PHASE_W'(next_acc + off_sel);
	assign cos_phase = PHASE_W'(phase_val + QUARTER_TURN);
	assign in_idx    = in_word.user[IDX_W-1:0];
	assign in_user   = (in_user_mode == TU_BOTH) ? in_word.user[TUSER_W-1:IDX_W] : in_word.user[USER_W-1:0];

	always_comb begin
		stage_in            = '0;
		stage_in.phase      = phase_val;
		// sawtooth stand-in for the lookup output
		stage_in.sine       = out_form(phase_val[PHASE_W-1 -: OUT_W], sign_mag);
		stage_in.cosine     = out_form(cos_phase[PHASE_W-1 -: OUT_W], sign_mag);
		stage_in.data_user  = out_user(data_user_mode, in_user_mode, in_user, chan);
		stage_in.phase_user = out_user(phase_user_mode, in_user_mode, in_user, chan);
		case (framing_mode)
			FRAME_VECTOR: stage_in.last = (chan == LAST_CH);
			FRAME_PACKET: stage_in.last = in_word.last;
			FRAME_CONFIG: stage_in.last = apply_now;
			default:      stage_in.last = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			chan <= '0;
		end else if (take) begin
			chan <= (chan == LAST_CH) ? '0 : IDX_W'(chan + 1'b1);
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cfg_ptr <= '0;
			pending <= 1'b0;
		end else if (cfg_take) begin
			cfg_ptr <= (s_config_last || cfg_ptr == LAST_CH) ? '0 : IDX_W'(cfg_ptr + 1'b1);
			if (s_config_last) begin
				pending <= 1'b1; // new frame wins over a same-cycle apply
			end else if (apply_now) begin
				pending <= 1'b0;
			end
		end else if (apply_now) begin
			pending <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (cfg_take) begin
			sh_inc[cfg_ptr] <= s_config.phase_increment_value;
			sh_off[cfg_ptr] <= s_config.phase_offset_value;
		end
	end

	always_ff @(posedge clock) begin
		for (int i = 0; i < CHANNELS; i++) begin
			if (!reset_n) begin
				act_inc[i] <= SLICE_REG ? '0 : INC_INIT[i*PHASE_W +: PHASE_W];
				act_off[i] <= SLICE_REG ? '0 : OFF_INIT[i*PHASE_W +: PHASE_W];
			end else if (apply_now) begin
				act_inc[i] <= sh_inc[i];
				act_off[i] <= sh_off[i];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			for (int i = 0; i < CHANNELS; i++) begin
				acc[i] <= RESET_PHASE;
			end
		end else if (take) begin
			acc[chan] <= next_acc;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			frame_end_missing_event      <= 1'b0;
			frame_end_unexpected_event   <= 1'b0;
			channel_index_mismatch_event <= 1'b0;
		end else if (clock_en) begin
			frame_end_missing_event    <= take && framing_mode == FRAME_VECTOR
				&& chan == LAST_CH && !in_word.last;
			frame_end_unexpected_event <= take && framing_mode == FRAME_VECTOR
				&& chan != LAST_CH && in_word.last;
			channel_index_mismatch_event <= take && (in_user_mode == TU_CHAN || in_user_mode == TU_BOTH)
				&& in_idx != chan;
		end
	end

	// fixed pipeline ahead of the queue; the queue write adds the final cycle
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			for (int k = 0; k <= TAP; k++) begin
				pvalid[k] <= 1'b0;
				pipe[k]   <= '0;
			end
		end else if (advance) begin
			pvalid[0] <= take;
			pipe[0]   <= stage_in;
			for (int k = 1; k <= TAP; k++) begin
				pvalid[k] <= pvalid[k-1];
				pipe[k]   <= pipe[k-1];
			end
		end
	end

	assign fifo_in       = (LAT_EFF == 1) ? stage_in : pipe[TAP];
	assign fifo_in_valid = advance && ((LAT_EFF == 1) ? take : pvalid[TAP]);

	dsc_fifo #(
		.WIDTH ($bits(dsc_sample_t)),
		.DEPTH (FIFO_DEPTH)
	) u_out_fifo (
		.clock     (clock),
		.reset_n   (reset_n),
		.enable    (clock_en),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (m_valid),
		.out_ready (HAS_TREADY ? m_ready : 1'b1),
		.out_data  (m_sample)
	);

	sequence s_pkt_end;
		take && in_word.last && framing_mode == FRAME_PACKET && !HAS_TREADY;
	endsequence

	sequence s_cfg_switch;
		framing_mode == FRAME_CONFIG && sync_mode == SYNC_VECTOR && pending && wrap && !HAS_TREADY;
	endsequence

	property p_packet_latency;
		@(posedge clock) disable iff (!reset_n || !clock_en)
		s_pkt_end |-> ##LAT_EFF (m_valid && m_sample.last);
	endproperty
	a_packet_latency: assert property (p_packet_latency) else $error("packet frame-end latency wrong");

	property p_cfg_frame_end;
		@(posedge clock) disable iff (!reset_n || !clock_en)
		s_cfg_switch |-> ##LAT_EFF (m_valid && m_sample.last);
	endproperty
	a_cfg_frame_end: assert property (p_cfg_frame_end) else $error("no frame-end before new config");

	property p_missing;
		@(posedge clock) disable iff (!reset_n)
		take && framing_mode == FRAME_VECTOR && chan == LAST_CH && !in_word.last |=> frame_end_missing_event;
	endproperty
	a_missing: assert property (p_missing) else $error("missing frame-end not flagged");

	property p_unexpected;
		@(posedge clock) disable iff (!reset_n)
		frame_end_unexpected_event |-> $past(in_word.last) && $past(chan) != LAST_CH;
	endproperty
	a_unexpected: assert property (p_unexpected) else $error("spurious unexpected frame-end event");

	property p_index;
		@(posedge clock) disable iff (!reset_n)
		take && (in_user_mode == TU_CHAN || in_user_mode == TU_BOTH) && in_idx != chan
			|=> channel_index_mismatch_event;
	endproperty
	a_index: assert property (p_index) else $error("index mismatch not flagged");

	property p_counter;
		@(posedge clock) disable iff (!reset_n)
		take |=> chan == (($past(chan) == LAST_CH) ? '0 : IDX_W'($past(chan) + 1'b1));
	endproperty
	a_counter: assert property (p_counter) else $error("channel counter step wrong");

	property p_vector_apply;
		@(posedge clock) disable iff (!reset_n)
		pending && sync_mode == SYNC_VECTOR && wrap |=> act_inc[0] == $past(sh_inc[0]) && act_off[0] == $past(sh_off[0]);
	endproperty
	a_vector_apply: assert property (p_vector_apply) else $error("config not applied on wrap");

	property p_hold_stall;
		@(posedge clock) disable iff (!reset_n)
		HAS_TREADY && m_valid && !m_ready |=> m_valid && $stable(m_sample);
	endproperty
	a_hold_stall: assert property (p_hold_stall) else $error("output dropped under back pressure");

	property p_clock_en;
		@(posedge clock) disable iff (!reset_n)
		!clock_en |=> $stable(chan) && $stable(pending) && $stable(m_valid);
	endproperty
	a_clock_en: assert property (p_clock_en) else $error("state moved with clock enable low");
endmodule : dsc_channel_ctrl

// ---- test/dsc_sink.sv ----
module dsc_sink (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic stall,
	input  wire logic slow,
	input  wire logic m_valid,
	output logic      m_ready
);
	logic toggle;

	// downstream consumer: ready every cycle, every other cycle, or never
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			toggle  <= 1'b0;
			m_ready <= 1'b0;
		end else begin
			toggle  <= ~toggle;
			m_ready <= !stall && (!slow || toggle);
		end
	end
endmodule : dsc_sink

// ---- test/dsc_channel_ctrl_bench.sv ----
module dsc_channel_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dsc_pkg::*;

	localparam logic [CHANNELS*PHASE_W-1:0] INC0 = {16'h0400, 16'h0300, 16'h0200, 16'h0100};
	localparam logic [CHANNELS*PHASE_W-1:0] OFF0 = {16'h0040, 16'h0030, 16'h0020, 16'h0010};

	typedef struct packed {
		logic               last;
		logic               ubit;
		logic               chk;
		logic [IDX_W-1:0]   idx;
		logic [PHASE_W-1:0] ph;
	} dsc_exp_t;

	logic            clock = 1'b0;
	logic            reset_n = 1'b0;
	logic            clock_en = 1'b1;
	dsc_framing_t    framing_mode = FRAME_NONE;
	dsc_sync_t       sync_mode = SYNC_VECTOR;
	logic            s_phase_valid = 1'b0;
	logic            s_phase_ready;
	dsc_phase_in_t   s_phase = '0;
	logic            s_config_valid = 1'b0;
	logic            s_config_ready;
	dsc_config_t     s_config = '0;
	logic            s_config_last = 1'b0;
	logic            m_valid;
	logic            m_ready;
	dsc_sample_t     m_sample;
	logic            ev_miss;
	logic            ev_unexp;
	logic            ev_idx;
	logic            stall = 1'b0;
	logic            slow = 1'b0;
	dsc_exp_t        exp_q[$];
	logic [PHASE_W-1:0] act_inc[CHANNELS];
	logic [PHASE_W-1:0] act_off[CHANNELS];
	logic [PHASE_W-1:0] sh_inc[CHANNELS];
	logic [PHASE_W-1:0] sh_off[CHANNELS];
	logic            pending;
	int              ch, cyc, acc_cyc, out_cyc, n;
	int              exp_miss, exp_unexp, exp_idx, got_miss, got_unexp, got_idx;
	int              miscompares = 0;
	int              total_checks = 0;

	always #5 clock = ~clock;

	dsc_channel_ctrl #(.HAS_TREADY(1'b1), .INC_INIT(INC0), .OFF_INIT(OFF0)) uut (
		.clock(clock), .reset_n(reset_n), .clock_en(clock_en), .framing_mode(framing_mode),
		.in_user_mode(TU_BOTH), .data_user_mode(TU_BOTH), .phase_user_mode(TU_BOTH),
		.sync_mode(sync_mode), .sign_mag(1'b0), .s_phase_valid(s_phase_valid),
		.s_phase_ready(s_phase_ready), .s_phase(s_phase), .s_config_valid(s_config_valid),
		.s_config_ready(s_config_ready), .s_config(s_config), .s_config_last(s_config_last),
		.m_valid(m_valid), .m_ready(m_ready), .m_sample(m_sample),
		.frame_end_missing_event(ev_miss), .frame_end_unexpected_event(ev_unexp),
		.channel_index_mismatch_event(ev_idx));

	dsc_sink sink (.clock(clock), .reset_n(reset_n), .stall(stall), .slow(slow),
		.m_valid(m_valid), .m_ready(m_ready));

	task check(input logic [47:0] seen, input logic [47:0] expv, input string what);
		total_checks++;
		if (seen !== expv) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : check

	task close_out;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	task do_reset(input dsc_framing_t mode, input dsc_sync_t sync, input int len);
		reset_n <= 1'b0;
		framing_mode <= mode;
		sync_mode <= sync;
		repeat (len) @(posedge clock);
		reset_n <= 1'b1;
		ch = 0;
		pending = 1'b0;
		exp_miss = 0;
		exp_unexp = 0;
		exp_idx = 0;
		got_miss = 0;
		got_unexp = 0;
		got_idx = 0;
		for (int k = 0; k < CHANNELS; k++) begin
			act_inc[k] = INC0[k*PHASE_W +: PHASE_W];
			act_off[k] = OFF0[k*PHASE_W +: PHASE_W];
		end
	endtask : do_reset

	// model of the channel counter and config buffer, one entry per accepted word
	task send_phase(input logic last, input logic ubit, input logic [IDX_W-1:0] idx);
		logic ok;
		logic apply;
		dsc_exp_t e;
		s_phase_valid <= 1'b1;
		s_phase <= '{phase_increment_value: 16'h0000, phase_offset_value: 16'h0000,
			resync: 1'b1, last: last, user: {ubit, idx}};
		ok = 1'b0;
		while (!ok) begin
			@(negedge clock);
			ok = (s_phase_ready === 1'b1) && clock_en;
			@(posedge clock);
		end
		acc_cyc = cyc;
		apply = pending && ((sync_mode == SYNC_PACKET) ? last : (ch == CHANNELS-1));
		e.last = (framing_mode == FRAME_VECTOR) ? (ch == CHANNELS-1) :
			(framing_mode == FRAME_PACKET) ? last : (framing_mode == FRAME_CONFIG) ? apply : 1'b0;
		e.ubit = ubit;
		e.chk = (idx == ch[IDX_W-1:0]);
		e.idx = ch[IDX_W-1:0];
		e.ph = act_inc[ch] + act_off[ch];
		exp_q.push_back(e);
		exp_unexp += (framing_mode == FRAME_VECTOR && last && ch != CHANNELS-1);
		exp_miss += (framing_mode == FRAME_VECTOR && !last && ch == CHANNELS-1);
		exp_idx += !e.chk;
		if (apply) begin
			act_inc = sh_inc;
			act_off = sh_off;
			pending = 1'b0;
		end
		ch = (ch == CHANNELS-1) ? 0 : ch + 1;
	endtask : send_phase

	task idle(input int len);
		s_phase_valid <= 1'b0;
		repeat (len) @(posedge clock);
	endtask : idle

	task send_cfg_set(input logic [PHASE_W-1:0] base);
		for (int k = 0; k < CHANNELS; k++) begin
			s_config_valid <= 1'b1;
			s_config <= '{base + 16'h0100 * k, base + 16'h0008 * k};
			s_config_last <= (k == CHANNELS-1);
			@(posedge clock);
			sh_inc[k] = base + 16'h0100 * k;
			sh_off[k] = base + 16'h0008 * k;
		end
		s_config_valid <= 1'b0;
		s_config_last <= 1'b0;
		pending = 1'b1;
	endtask : send_cfg_set

	task drain(input string name);
		idle(1);
		for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clock);
		idle(4);
		check(exp_q.size(), 0, "outputs missing");
		check(got_miss, exp_miss, "missing frame-end events");
		check(got_unexp, exp_unexp, "unexpected frame-end events");
		check(got_idx, exp_idx, "index mismatch events");
		$display("test %s done", name);
	endtask : drain

	always @(posedge clock) begin
		dsc_exp_t e;
		cyc <= cyc + 1;
		if (reset_n === 1'b1 && clock_en === 1'b1) begin
			got_miss += (ev_miss === 1'b1);
			got_unexp += (ev_unexp === 1'b1);
			got_idx += (ev_idx === 1'b1);
			if (m_valid === 1'b1 && m_ready === 1'b1) begin
				out_cyc = cyc;
				if (exp_q.size() == 0) begin
					check(1, 0, "extra output");
				end else begin
					e = exp_q.pop_front();
					check(m_sample.last, e.last, "frame-end");
					check(m_sample.data_user[TUSER_W-1], e.ubit, "data user field");
					check(m_sample.phase_user[TUSER_W-1], e.ubit, "phase user field");
					if (e.chk)
						check(m_sample.data_user[IDX_W-1:0], e.idx, "index bits");
					check(m_sample.phase, e.ph, "phase");
					check(m_sample.sine, e.ph[PHASE_W-1 -: OUT_W], "sine form");
					check(m_sample.cosine, (e.ph + QUARTER_TURN) >> (PHASE_W - OUT_W), "cosine form");
				end
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		close_out();
	end

	initial begin
		logic [$bits(dsc_sample_t)-1:0] held;
		cyc = 0;
		do_reset(FRAME_NONE, SYNC_VECTOR, 12);
		check(m_valid, 0, "valid after reset");
		for (int i = 0; i < 8; i++) send_phase(1'b1, i[0], i[IDX_W-1:0]);
		drain("none");
		do_reset(FRAME_VECTOR, SYNC_VECTOR, 2);
		for (int i = 0; i < 8; i++) send_phase(i == 1 || (i % 4 == 3 && i != 7), i[1], (i == 5) ? 2'h0 : i[IDX_W-1:0]);
		drain("vector");
		do_reset(FRAME_PACKET, SYNC_VECTOR, 2);
		send_phase(1'b1, 1'b1, 2'h0);
		idle(12);
		check(out_cyc - acc_cyc, BP_MIN_LAT, "latency");
		slow <= 1'b1;
		for (int i = 1; i < 8; i++) send_phase(i[0], i[1], i[IDX_W-1:0]);
		drain("packet");
		slow <= 1'b0;
		stall <= 1'b1;
		idle(3);
		// queue plus the fixed pipeline ahead of it absorb this many words
		for (n = 0; n < FIFO_DEPTH + BP_MIN_LAT - 1; n++) begin
			send_phase(1'b0, 1'b1, ch[IDX_W-1:0]);
		end
		idle(8);
		check(n >= FIFO_DEPTH, 1, "refused too early");
		check(s_phase_ready, 0, "ready while full");
		clock_en <= 1'b0;
		@(negedge clock);
		held = m_sample;
		repeat (3) @(negedge clock);
		check({m_valid, m_sample}, {1'b1, held}, "held with enable low");
		check(s_config_ready, 0, "config ready with enable low");
		@(posedge clock);
		clock_en <= 1'b1;
		stall <= 1'b0;
		drain("back pressure");
		do_reset(FRAME_CONFIG, SYNC_VECTOR, 2);
		send_phase(1'b0, 1'b0, 2'h0);
		send_phase(1'b0, 1'b1, 2'h1);
		idle(1);
		send_cfg_set(16'h1000);
		for (int i = 2; i < 10; i++) send_phase(1'b0, i[0], i[IDX_W-1:0]);
		drain("config vector");
		do_reset(FRAME_PACKET, SYNC_PACKET, 2);
		send_cfg_set(16'h2000);
		for (int i = 0; i < 6; i++) send_phase(i == 1, i[0], i[IDX_W-1:0]);
		drain("config packet");
		close_out();
	end
endmodule : dsc_channel_ctrl_bench
